/* core/motor_driver_fault_manager.sv */
// fault response, recovery and reporting of the motor driver
// Notes on behaviour
// RULE1 - any active latched or retry fault pulls the fault pin low
// RULE2 - alarm enable set: alarm pin also goes high for actionable faults
// RULE3 - report-only faults use fault pin if alarm off, else alarm pin only
// RULE4 - priority: latched, longer retry, shorter retry, then report-only
// RULE5 - latched plus retry together: stay latched until host clears
// RULE6 - two retry faults together: retry after the longer interval only
// RULE7 - retry recovery re-enables outputs after interval once fault has gone
// RULE8 - latched faults keep outputs off until the host writes clear
// RULE9 - actionable fault report may lag the Hi-Z action up to 200 ms
// RULE10 - latched fault clear may take up to 200 ms after the command
// RULE11 - supply or analog undervoltage: Hi-Z, logic off, no report, auto recover
// RULE12 - regulator undervoltage: auto recover, no report
// RULE13 - pump undervoltage: Hi-Z, report on pin and gate flags, auto recover
// RULE14 - overvoltage: ignored if protection off, else Hi-Z, report, auto recover
// RULE15 - phase overcurrent mode: latched, retry, report-only or nothing
// RULE16 - regulator overcurrent: Hi-Z, logic off, no report, auto recover
// RULE17 - lock modes 0 to 3: latched Hi-Z, high brake or low brake
// RULE18 - lock modes 4 to 7 retry; 8 reports only; 1xx1 does nothing
// RULE19 - cycle limit modes 0,1: recirculate, resume next cycle, report mode 0
// RULE20 - cycle limit modes 2,3: recirculate until current drops
// RULE21 - cycle limit modes 4,5: resume after more than the set cycle count
// RULE22 - cycle limit mode 6 reports only; 7 and above do nothing
// RULE23 - flags held until cleared or recovered; pins released when none remain
`timescale 1ns/100ps
`default_nettype none
module motor_driver_fault_manager
  import fault_mgr_pkg::*;
#(
  parameter int CYC_W          = 8,
  parameter int REPORT_CYC     = REPORT_DELAY_CYC,
  parameter int RETRY_CYC      = RETRY_CYC_DEF,
  parameter int LOCK_RETRY_CYC = LOCK_RETRY_CYC_DEF
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // detections, high while the condition is present
  input  wire logic             supplyUndervoltage,
  input  wire logic             analogUndervoltage,
  input  wire logic             regulator_undervoltage_fault,
  input  wire logic             regulator_overcurrent_fault,
  input  wire logic             pump_undervoltage_fault,
  input  wire logic             supply_overvoltage_fault,
  input  wire logic             phase_overcurrent_fault,
  input  wire logic             motor_lock_fault,
  input  wire logic             cycle_current_limit,
  input  wire logic             pwmStart,
  // configuration
  input  wire logic             alarmPinEnable,
  input  wire logic             overvoltage_protect_enable,
  input  wire logic [1:0]       phase_overcurrent_mode,
  input  wire logic [3:0]       motor_lock_mode,
  input  wire logic [3:0]       cycle_limit_mode,
  input  wire logic [CYC_W-1:0] cycle_limit_retry_count,
  // host command, one-cycle pulse
  input  wire logic             clear_fault_bit,
  // power stage
  output logic                  stageHiZ,
  output logic                  stageHsBrake,
  output logic                  stageLsBrake,
  output logic                  stageRecirc,
  output logic                  logicEnable,
  // reporting
  output logic                  fault_indicator_n,
  output logic                  alarmPin,
  output logic [2:0]            gate_stage_fault_flags,
  output logic [1:0]            control_fault_flags
);

  typedef struct packed {
    rec_t        rec;
    stage_t      stage;
    logic        latchOcp;
    logic        latchLock;
    logic        retryOcp;
    logic        retryLock;
    logic [31:0] ocpTimer;
    logic [31:0] lockTimer;
    logic [31:0] repTimer;
    logic        reported;
    logic        clearPend;
    logic [31:0] clrTimer;
    logic        faultN;
    logic        alarm;
    logic [2:0]  gateFlags;
    logic [1:0]  ctrlFlags;
    logic        hiZ;
    logic        hsb;
    logic        lsb;
    logic        recirc;
    logic        logicOn;
  } mgr_state_t;

  localparam logic [31:0] REP_LAST   = 32'(REPORT_CYC);
  localparam logic [31:0] RETRY_LAST = 32'(RETRY_CYC);
  localparam logic [31:0] LOCK_LAST  = 32'(LOCK_RETRY_CYC);

  mgr_state_t st_ff;
  mgr_state_t nxt_st;
  logic       climRecirc;
  logic       climReport;

  // current limit handled in its own unit
  cycle_limit_unit #(
    .CYC_W(CYC_W)
  ) u_climit (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .cycle_current_limit     (cycle_current_limit),
    .pwmStart                (pwmStart),
    .cycle_limit_mode        (cycle_limit_mode),
    .cycle_limit_retry_count (cycle_limit_retry_count),
    .recircOn                (climRecirc),
    .limitReport             (climReport)
  );

  // saturating count toward a limit
  function automatic logic [31:0] tick(input logic [31:0] v, input logic [31:0] lim);
    tick = (v < lim) ? v + 32'h1 : v;
  endfunction

  // decoded configuration
  logic   ocpLatchMode;
  logic   ocpRetryMode;
  logic   ocpReportMode;
  logic   lockLatchMode;
  logic   lockRetryMode;
  logic   lockReportMode;
  stage_t lockStage;
  logic   supplyDown;
  logic   ovpHit;
  logic   actionable;
  logic   reportOnly;
  logic   ocpRetryActive;
  logic   lockRetryActive;

  always_comb begin
    ocpLatchMode   = (phase_overcurrent_mode == OC_LATCH);  // see RULE15
    ocpRetryMode   = (phase_overcurrent_mode == OC_RETRY);  // see RULE15
    ocpReportMode  = (phase_overcurrent_mode == OC_REPORT); // see RULE15
    lockLatchMode  = (motor_lock_mode[3:2] == 2'h0);        // see RULE17
    lockRetryMode  = (motor_lock_mode[3:2] == 2'h1);        // see RULE18
    lockReportMode = (motor_lock_mode == LK_REPORT);        // see RULE18
    case (motor_lock_mode)
      LK_HSB, LK_R_HSB: lockStage = STAGE_HS_BRK; // see RULE17
      LK_LSB, LK_R_LSB: lockStage = STAGE_LS_BRK; // see RULE17
      default:          lockStage = STAGE_HIZ;
    endcase
    supplyDown = supplyUndervoltage || analogUndervoltage
                 || regulator_overcurrent_fault; // see RULE11
    ovpHit     = supply_overvoltage_fault && overvoltage_protect_enable; // see RULE14
    ocpRetryActive  = st_ff.retryOcp;
    lockRetryActive = st_ff.retryLock;
    actionable = st_ff.latchOcp || st_ff.latchLock || ocpRetryActive || lockRetryActive
                 || pump_undervoltage_fault || ovpHit;
    reportOnly = (phase_overcurrent_fault && ocpReportMode)
                 || (motor_lock_fault && lockReportMode) || climReport; // see RULE22
  end

  always_comb begin
    nxt_st = st_ff;
    // latching faults capture and hold; set beats clear
    if (phase_overcurrent_fault && ocpLatchMode) begin
      nxt_st.latchOcp = 1'b1; // see RULE8
    end
    if (motor_lock_fault && lockLatchMode) begin
      nxt_st.latchLock = 1'b1; // see RULE17
    end
    if (phase_overcurrent_fault && ocpRetryMode) begin
      nxt_st.retryOcp = 1'b1;
      nxt_st.ocpTimer = '0;
    end else if (st_ff.retryOcp) begin
      // interval runs only once the condition has gone
      nxt_st.ocpTimer = tick(st_ff.ocpTimer, RETRY_LAST); // see RULE7
    end
    if (motor_lock_fault && lockRetryMode) begin
      nxt_st.retryLock = 1'b1;
      nxt_st.lockTimer = '0;
    end else if (st_ff.retryLock) begin
      nxt_st.lockTimer = tick(st_ff.lockTimer, LOCK_LAST); // see RULE18
    end
    // clear command: takes effect after a fixed settling delay
    if (clear_fault_bit) begin
      nxt_st.clearPend = 1'b1;
      nxt_st.clrTimer  = '0;
    end else if (st_ff.clearPend) begin
      nxt_st.clrTimer = tick(st_ff.clrTimer, REP_LAST);
      if (st_ff.clrTimer == REP_LAST) begin
        nxt_st.clearPend = 1'b0; // see RULE10
        if (!(phase_overcurrent_fault && ocpLatchMode)) begin
          nxt_st.latchOcp = 1'b0; // see RULE8
        end
        if (!(motor_lock_fault && lockLatchMode)) begin
          nxt_st.latchLock = 1'b0;
        end
      end
    end
    // both retry faults drop together once the longer interval is done
    if (st_ff.retryOcp || st_ff.retryLock) begin
      if ((!st_ff.retryOcp || st_ff.ocpTimer == RETRY_LAST)
          && (!st_ff.retryLock || st_ff.lockTimer == LOCK_LAST)
          && !(phase_overcurrent_fault && ocpRetryMode)
          && !(motor_lock_fault && lockRetryMode)) begin
        nxt_st.retryOcp  = 1'b0; // see RULE6
        nxt_st.retryLock = 1'b0; // see RULE6
      end
    end
    // recovery state, priority order
    if (st_ff.latchOcp || st_ff.latchLock) begin
      nxt_st.rec = REC_LATCH; // see RULE4 RULE5
    end else if (st_ff.retryOcp || st_ff.retryLock) begin
      nxt_st.rec = REC_RETRY; // see RULE4
    end else if (actionable) begin
      nxt_st.rec = REC_WAIT;
    end else begin
      nxt_st.rec = REC_IDLE;
    end
    // power stage action, most severe wins
    nxt_st.stage = STAGE_ACTIVE;
    if (climRecirc) begin
      nxt_st.stage = STAGE_RECIRC; // see RULE19
    end
    if (st_ff.retryLock && lockStage != STAGE_HIZ) begin
      nxt_st.stage = lockStage; // see RULE18
    end
    if (st_ff.latchLock && lockStage != STAGE_HIZ) begin
      nxt_st.stage = lockStage; // see RULE17
    end
    if (supplyDown || pump_undervoltage_fault || ovpHit
        || st_ff.latchOcp || st_ff.retryOcp
        || (st_ff.latchLock && lockStage == STAGE_HIZ)
        || (st_ff.retryLock && lockStage == STAGE_HIZ)) begin
      nxt_st.stage = STAGE_HIZ; // see RULE11 RULE13 RULE14 RULE15
    end
    nxt_st.hiZ     = (nxt_st.stage == STAGE_HIZ);
    nxt_st.hsb     = (nxt_st.stage == STAGE_HS_BRK);
    nxt_st.lsb     = (nxt_st.stage == STAGE_LS_BRK);
    nxt_st.recirc  = (nxt_st.stage == STAGE_RECIRC);
    // regulator undervoltage leaves logic running; choice allowed
    nxt_st.logicOn = !supplyDown; // see RULE11 RULE12 RULE16
    // report lag after an actionable fault begins, bounded by the report delay
    if (actionable) begin
      nxt_st.repTimer = tick(st_ff.repTimer, REP_LAST);
      nxt_st.reported = st_ff.reported || (st_ff.repTimer == REP_LAST); // see RULE9
    end else begin
      nxt_st.repTimer = '0;
      nxt_st.reported = 1'b0; // see RULE23
    end
    // pins; undervoltage of supply gives no report at all
    if (supplyDown) begin
      nxt_st.faultN    = 1'b1; // see RULE11
      nxt_st.alarm     = 1'b0;
      nxt_st.gateFlags = '0;
      nxt_st.ctrlFlags = '0;
    end else begin
      nxt_st.faultN = !((actionable && st_ff.reported)
                        || (reportOnly && !alarmPinEnable)); // see RULE1 RULE3 RULE23
      nxt_st.alarm  = alarmPinEnable
                      && ((actionable && st_ff.reported) || reportOnly); // see RULE2 RULE3
      nxt_st.gateFlags[GF_PUMP_UV] = pump_undervoltage_fault && st_ff.reported; // see RULE13
      nxt_st.gateFlags[GF_OVP]     = ovpHit && st_ff.reported; // see RULE14
      nxt_st.gateFlags[GF_OCP]     = ((st_ff.latchOcp || st_ff.retryOcp) && st_ff.reported)
                                     || (phase_overcurrent_fault && ocpReportMode);
      nxt_st.ctrlFlags[CF_LOCK]    = ((st_ff.latchLock || st_ff.retryLock) && st_ff.reported)
                                     || (motor_lock_fault && lockReportMode); // see RULE23
      nxt_st.ctrlFlags[CF_CLIMIT]  = climReport;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= '0;
      st_ff.faultN  <= 1'b1;
      st_ff.logicOn <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stageHiZ               = st_ff.hiZ;
  assign stageHsBrake           = st_ff.hsb;
  assign stageLsBrake           = st_ff.lsb;
  assign stageRecirc            = st_ff.recirc;
  assign logicEnable            = st_ff.logicOn;
  assign fault_indicator_n      = st_ff.faultN;
  assign alarmPin               = st_ff.alarm;
  assign gate_stage_fault_flags = st_ff.gateFlags;
  assign control_fault_flags    = st_ff.ctrlFlags;

endmodule
`default_nettype wire

/* core/fault_mgr_pkg.sv */
// constants and types shared by the fault manager
package fault_mgr_pkg;

  // power stage actions, ordered by severity
  typedef enum logic [2:0] {
    STAGE_ACTIVE  = 3'h0,
    STAGE_RECIRC  = 3'h1,
    STAGE_LS_BRK  = 3'h2,
    STAGE_HS_BRK  = 3'h3,
    STAGE_HIZ     = 3'h4
  } stage_t;

  // recovery state of the actionable-fault machine
  typedef enum logic [1:0] {
    REC_IDLE   = 2'h0,
    REC_LATCH  = 2'h1,
    REC_RETRY  = 2'h2,
    REC_WAIT   = 2'h3
  } rec_t;

  localparam logic [1:0] OC_LATCH   = 2'h0;
  localparam logic [1:0] OC_RETRY   = 2'h1;
  localparam logic [1:0] OC_REPORT  = 2'h2;

  localparam logic [3:0] LK_HIZ_A   = 4'h0;
  localparam logic [3:0] LK_HIZ_B   = 4'h1;
  localparam logic [3:0] LK_HSB     = 4'h2;
  localparam logic [3:0] LK_LSB     = 4'h3;
  localparam logic [3:0] LK_R_HIZ_A = 4'h4;
  localparam logic [3:0] LK_R_HIZ_B = 4'h5;
  localparam logic [3:0] LK_R_HSB   = 4'h6;
  localparam logic [3:0] LK_R_LSB   = 4'h7;
  localparam logic [3:0] LK_REPORT  = 4'h8;

  localparam logic [3:0] CL_NEXT_R  = 4'h0;
  localparam logic [3:0] CL_NEXT_U  = 4'h1;
  localparam logic [3:0] CL_HOLD_R  = 4'h2;
  localparam logic [3:0] CL_HOLD_U  = 4'h3;
  localparam logic [3:0] CL_CNT_R   = 4'h4;
  localparam logic [3:0] CL_CNT_U   = 4'h5;
  localparam logic [3:0] CL_REPORT  = 4'h6;

  // gate stage flag bits
  localparam int GF_PUMP_UV = 0;
  localparam int GF_OVP     = 1;
  localparam int GF_OCP     = 2;
  // control flag bits
  localparam int CF_LOCK    = 0;
  localparam int CF_CLIMIT  = 1;

  // timing
  localparam int CLK_HZ             = 50_000_000;
  localparam int REPORT_DELAY_MS    = 200;
  localparam int REPORT_DELAY_CYC   = REPORT_DELAY_MS * (CLK_HZ / 1000);
  localparam int RETRY_MS_DEF       = 500;
  localparam int LOCK_RETRY_MS_DEF  = 1000;
  localparam int RETRY_CYC_DEF      = RETRY_MS_DEF * (CLK_HZ / 1000);
  localparam int LOCK_RETRY_CYC_DEF = LOCK_RETRY_MS_DEF * (CLK_HZ / 1000);
  localparam int CNT_W              = 32;

endpackage

/* core/cycle_limit_unit.sv */
// cycle-by-cycle current limit response
`timescale 1ns/100ps
`default_nettype none
module cycle_limit_unit
  import fault_mgr_pkg::*;
#(
  parameter int CYC_W = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // detection and setup
  input  wire logic             cycle_current_limit,
  input  wire logic             pwmStart,
  input  wire logic [3:0]       cycle_limit_mode,
  input  wire logic [CYC_W-1:0] cycle_limit_retry_count,
  // response
  output logic                  recircOn,
  output logic                  limitReport
);

  typedef struct packed {
    logic             recirc;
    logic             report;
    logic [CYC_W-1:0] cycles;
  } cl_state_t;

  cl_state_t st_ff;
  cl_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (cycle_limit_mode)
      CL_NEXT_R, CL_NEXT_U: begin
        // resume at the next switching cycle
        if (cycle_current_limit) begin
          nxt_st.recirc = 1'b1; // see RULE19
        end else if (pwmStart) begin
          nxt_st.recirc = 1'b0; // see RULE19
        end
        nxt_st.report = nxt_st.recirc && (cycle_limit_mode == CL_NEXT_R); // see RULE19
        nxt_st.cycles = '0;
      end
      CL_HOLD_R, CL_HOLD_U: begin
        nxt_st.recirc = cycle_current_limit; // see RULE20
        nxt_st.report = cycle_current_limit && (cycle_limit_mode == CL_HOLD_R); // see RULE20
        nxt_st.cycles = '0;
      end
      CL_CNT_R, CL_CNT_U: begin
        if (!st_ff.recirc) begin
          nxt_st.recirc = cycle_current_limit;
          nxt_st.cycles = '0;
        end else if (pwmStart) begin
          // this start ends switching cycle cycles+1
          if (st_ff.cycles >= cycle_limit_retry_count) begin
            nxt_st.recirc = 1'b0; // see RULE21
            nxt_st.cycles = '0;
          end else if (st_ff.cycles != '1) begin
            nxt_st.cycles = st_ff.cycles + 1'b1;
          end
        end
        nxt_st.report = nxt_st.recirc && (cycle_limit_mode == CL_CNT_R); // see RULE21
      end
      CL_REPORT: begin
        nxt_st.recirc = 1'b0;
        nxt_st.report = cycle_current_limit; // see RULE22
        nxt_st.cycles = '0;
      end
      default: begin
        nxt_st = '0; // see RULE22
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign recircOn    = st_ff.recirc;
  assign limitReport = st_ff.report;

endmodule
`default_nettype wire

/* verif/fault_mgr_assertions.sv */
// concurrent checks on the fault manager ports
`timescale 1ns/100ps
`default_nettype none
module fault_mgr_checker
  import fault_mgr_pkg::*;
#(
  parameter int REPORT_CYC = 20
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // detections
  input wire logic       supplyUndervoltage,
  input wire logic       analogUndervoltage,
  input wire logic       regulator_undervoltage_fault,
  input wire logic       regulator_overcurrent_fault,
  input wire logic       pump_undervoltage_fault,
  input wire logic       supply_overvoltage_fault,
  input wire logic       phase_overcurrent_fault,
  input wire logic       motor_lock_fault,
  input wire logic       cycle_current_limit,
  // configuration and host
  input wire logic       alarmPinEnable,
  input wire logic       overvoltage_protect_enable,
  input wire logic [1:0] phase_overcurrent_mode,
  input wire logic [3:0] cycle_limit_mode,
  input wire logic       clear_fault_bit,
  // responses
  input wire logic       stageHiZ,
  input wire logic       stageHsBrake,
  input wire logic       stageLsBrake,
  input wire logic       stageRecirc,
  input wire logic       logicEnable,
  input wire logic       fault_indicator_n,
  input wire logic       alarmPin,
  input wire logic [2:0] gate_stage_fault_flags,
  input wire logic [1:0] control_fault_flags
);
  logic [7:0] hizCnt_ff;
  logic [7:0] clrAge_ff;
  logic       calm;

  // no detection other than phase overcurrent or current limit, and no hard stage action
  assign calm = !(supplyUndervoltage || analogUndervoltage || regulator_undervoltage_fault ||
    regulator_overcurrent_fault || pump_undervoltage_fault || supply_overvoltage_fault ||
    motor_lock_fault || stageHiZ || stageHsBrake || stageLsBrake);

  // saturating ages, so long holds never wrap back into the window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hizCnt_ff <= 8'h00;
      clrAge_ff <= 8'h00;
    end else begin
      hizCnt_ff <= !(stageHiZ && logicEnable) ? 8'h00 : hizCnt_ff + 8'(hizCnt_ff != 8'hff);
      clrAge_ff <= clear_fault_bit ? 8'h00 : clrAge_ff + 8'(clrAge_ff != 8'hff);
    end
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  uv_logic_off_a: assert property (
    (supplyUndervoltage || analogUndervoltage)[*3]
      |-> stageHiZ && !logicEnable && fault_indicator_n && !alarmPin)
    else $error("undervoltage response wrong");
  regulator_overcurrent_fault_off_a: assert property (
    regulator_overcurrent_fault[*3] |-> stageHiZ && !logicEnable && fault_indicator_n)
    else $error("regulator overcurrent response wrong");
  pump_hiz_a: assert property (pump_undervoltage_fault[*3] |-> stageHiZ)
    else $error("pump undervoltage without hi-z");
  ovp_hiz_a: assert property (
    (supply_overvoltage_fault && overvoltage_protect_enable)[*3] |-> stageHiZ)
    else $error("overvoltage without hi-z");
  act_pin_a: assert property (hizCnt_ff == REPORT_CYC + 4 |-> !fault_indicator_n)
    else $error("actionable fault not on fault pin");
  act_alarm_a: assert property (
    hizCnt_ff == REPORT_CYC + 4 && alarmPinEnable |-> alarmPin)
    else $error("actionable fault not on alarm pin");
  report_only_a: assert property (
    (phase_overcurrent_fault && phase_overcurrent_mode == OC_REPORT && calm &&
      !cycle_current_limit && !stageRecirc)[*3]
      |-> fault_indicator_n == alarmPinEnable && alarmPin == alarmPinEnable)
    else $error("report-only pin routing wrong");
  ocp_ignored_a: assert property (
    (phase_overcurrent_fault && phase_overcurrent_mode == 2'h3 && calm &&
      !cycle_current_limit && !stageRecirc)[*3] |-> fault_indicator_n && !alarmPin)
    else $error("ignored overcurrent was reported");
  latch_hold_a: assert property (
    gate_stage_fault_flags[GF_OCP] && phase_overcurrent_mode == OC_LATCH &&
      clrAge_ff > REPORT_CYC + 8 |=> stageHiZ)
    else $error("latched overcurrent released without clear");
  limit_hold_a: assert property (
    (cycle_current_limit && cycle_limit_mode == CL_HOLD_R && calm && !phase_overcurrent_fault)[*4]
      |-> stageRecirc && control_fault_flags[CF_CLIMIT])
    else $error("current limit not recirculating");
endmodule

bind motor_driver_fault_manager fault_mgr_checker #(.REPORT_CYC(REPORT_CYC)) i_chk (
  .ref_clk, .rst_n, .supplyUndervoltage, .analogUndervoltage, .regulator_undervoltage_fault,
  .regulator_overcurrent_fault, .pump_undervoltage_fault, .supply_overvoltage_fault,
  .phase_overcurrent_fault, .motor_lock_fault, .cycle_current_limit, .alarmPinEnable,
  .overvoltage_protect_enable, .phase_overcurrent_mode, .cycle_limit_mode, .clear_fault_bit,
  .stageHiZ, .stageHsBrake, .stageLsBrake, .stageRecirc, .logicEnable, .fault_indicator_n,
  .alarmPin, .gate_stage_fault_flags, .control_fault_flags);
`default_nettype wire

/* verif/fault_host.sv */
// host controller model: issues clears and watches the fault pins
`timescale 1ns/100ps
`default_nettype none
module fault_host (
  // clock
  input  wire logic ref_clk,
  // fault pins
  input  wire logic fault_indicator_n,
  input  wire logic alarmPin,
  // command to the device
  output var logic  clear_fault_bit
);
  initial clear_fault_bit = 1'b0;

  // one-cycle clear, launched off the sampling edge
  task automatic clearFault();
    @(negedge ref_clk);
    clear_fault_bit = 1'b1;
    @(negedge ref_clk);
    clear_fault_bit = 1'b0;
  endtask

  // report may lag the stage action, so wait up to the whole window, stopping once a pin shows it
  task automatic waitReport(input int lim, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge ref_clk);
      seen = !fault_indicator_n || alarmPin;
    end
  endtask
endmodule
`default_nettype wire

/* verif/motor_driver_fault_manager_test.sv */
// self-checking bench for the fault manager
`timescale 1ns/100ps
`default_nettype none
module motor_driver_fault_manager_test
  import fault_mgr_pkg::*;
;
  localparam int          RC   = 20;
  localparam int          RT   = 30;
  localparam int          LRT  = 60;
  localparam logic [3:0]  HZ   = 4'h8;
  localparam logic [11:0] IDLE = 12'ha00;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  det = '0;
  logic        ocpF = 1'b0, lockF = 1'b0, limF = 1'b0, pwm = 1'b0;
  logic        alarmEn = 1'b0, ovpEn = 1'b1, rp, hold;
  logic [1:0]  ocpMode = OC_LATCH;
  logic [3:0]  lockMode = '0, limMode = '0, st;
  logic        clear_fault_bit, hiz, hsb, lsb, rcc, logicEn, fault_indicator_n, alarmPin;
  logic [2:0]  gFlags;
  logic [1:0]  cFlags;
  logic [11:0] ex [7];
  bit          seen;
  int          miscompares = 0, nChecks = 0, cycles = 0;
  wire logic [11:0] obs = {fault_indicator_n, alarmPin, logicEn, hiz, hsb, lsb, rcc, gFlags, cFlags};

  motor_driver_fault_manager #(.REPORT_CYC(RC), .RETRY_CYC(RT), .LOCK_RETRY_CYC(LRT)) i_dut (
    .ref_clk, .rst_n, .supplyUndervoltage(det[0]), .analogUndervoltage(det[1]),
    .regulator_undervoltage_fault(det[2]), .regulator_overcurrent_fault(det[3]),
    .pump_undervoltage_fault(det[4]), .supply_overvoltage_fault(det[5]),
    .phase_overcurrent_fault(ocpF), .motor_lock_fault(lockF), .cycle_current_limit(limF),
    .pwmStart(pwm), .alarmPinEnable(alarmEn), .overvoltage_protect_enable(ovpEn),
    .phase_overcurrent_mode(ocpMode), .motor_lock_mode(lockMode), .cycle_limit_mode(limMode),
    .cycle_limit_retry_count(8'h03), .clear_fault_bit, .stageHiZ(hiz), .stageHsBrake(hsb),
    .stageLsBrake(lsb), .stageRecirc(rcc), .logicEnable(logicEn), .fault_indicator_n,
    .alarmPin, .gate_stage_fault_flags(gFlags), .control_fault_flags(cFlags));
  fault_host host (.ref_clk, .fault_indicator_n, .alarmPin, .clear_fault_bit);

  always #10 ref_clk = ~ref_clk;

  function automatic logic [11:0] w(logic fn, al, le, logic [3:0] s, logic [2:0] g, logic [1:0] c);
    return {fn, al, le, s, g, c};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic chk(input logic [11:0] exp);
    nChecks++;
    if (obs !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, obs, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    cyc(1);
    chk(IDLE);
    // latched overcurrent, alarm pin in use
    alarmEn = 1'b1;
    ocpF = 1'b1;
    cyc(3);
    chk(w('1, '0, '1, HZ, '0, '0));
    host.waitReport(RC + 4, seen);
    if (!seen) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no report", $time);
    end
    cyc(2);
    chk(w('0, '1, '1, HZ, 3'h4, '0));
    ocpF = 1'b0;
    cyc(100);
    chk(w('0, '1, '1, HZ, 3'h4, '0));
    host.clearFault();
    cyc(RC + 8);
    chk(IDLE);
    // retry overcurrent recovers with no host action
    ocpMode = OC_RETRY;
    ocpF = 1'b1;
    cyc(RC + 8);
    chk(w('0, '1, '1, HZ, 3'h4, '0));
    ocpF = 1'b0;
    cyc(RT - 4);
    chk(w('0, '1, '1, HZ, 3'h4, '0));
    cyc(12);
    chk(IDLE);
    // report-only under both alarm settings, then the ignored code
    for (int a = 0; a < 2; a++) begin
      alarmEn = a[0];
      ocpMode = OC_REPORT;
      ocpF = 1'b1;
      cyc(3);
      chk(w(a[0], a[0], '1, '0, 3'h4, '0));
      ocpMode = 2'h3;
      cyc(3);
      chk(IDLE);
      ocpF = 1'b0;
    end
    // every lock code except the unlisted 1xx0 ones
    alarmEn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i > 8 && !i[0]) continue;
      st = (i > 7) ? 4'h0 : (i[1:0] == 2'h2) ? 4'h4 : (i[1:0] == 2'h3) ? 4'h2 : HZ;
      lockMode = 4'(i);
      lockF = 1'b1;
      cyc(RC + 6);
      chk(w(i > 8, '0, '1, st, '0, {1'b0, i <= 8}));
      lockF = 1'b0;
      cyc(LRT + 10);
      chk(i < 4 ? w('0, '0, '1, st, '0, 2'h1) : IDLE);
      host.clearFault();
      cyc(RC + 8);
      chk(IDLE);
    end
    // cycle limit codes, recovery by current drop or switching cycles
    for (int i = 0; i < 9; i++) begin
      limMode = 4'(i);
      rp = i < 7 && !i[0];
      limF = 1'b1;
      cyc(4);
      chk(w(!rp, '0, '1, {3'h0, i < 6}, '0, {rp, 1'b0}));
      limF = 1'b0;
      cyc(3);
      hold = i < 2 || i == 4 || i == 5;
      chk(w(!(rp && hold), '0, '1, {3'h0, hold}, '0, {rp && hold, 1'b0}));
      for (int p = 1; p < 5; p++) begin
        pwm = 1'b1;
        cyc(1);
        pwm = 1'b0;
        cyc(3);
        hold = p < 4 && (i == 4 || i == 5);
        chk(w(!(rp && hold), '0, '1, {3'h0, hold}, '0, {rp && hold, 1'b0}));
      end
    end
    // latched overcurrent beside a lock retry stays latched
    ocpMode = OC_LATCH;
    lockMode = LK_R_HIZ_A;
    ocpF = 1'b1;
    lockF = 1'b1;
    cyc(RC + 8);
    ocpF = 1'b0;
    lockF = 1'b0;
    cyc(LRT + 20);
    chk(w('0, '0, '1, HZ, 3'h4, '0));
    host.clearFault();
    cyc(RC + 8);
    chk(IDLE);
    // two retry faults wait for the longer interval
    ocpMode = OC_RETRY;
    ocpF = 1'b1;
    lockF = 1'b1;
    cyc(RC + 8);
    ocpF = 1'b0;
    lockF = 1'b0;
    cyc(RT + 10);
    chk(w('0, '0, '1, HZ, 3'h4, 2'h1));
    cyc(LRT - RT + 10);
    chk(IDLE);
    // supply side detections, last one with protection off
    ex = '{w('1, '0, '0, HZ, '0, '0), w('1, '0, '0, HZ, '0, '0), IDLE,
      w('1, '0, '0, HZ, '0, '0), w('0, '0, '1, HZ, 3'h1, '0), w('0, '0, '1, HZ, 3'h2, '0), IDLE};
    for (int k = 0; k < 7; k++) begin
      ovpEn = k != 6;
      det = (k == 6) ? 6'h20 : 6'(1 << k);
      cyc(RC + 6);
      chk(ex[k]);
      det = '0;
      cyc(4);
      chk(IDLE);
    end
    summarize();
  end
endmodule
`default_nettype wire
